// ---- cdg_params.svh ----
// Purpose: Named constants of the coded door guard evaluator
// Assumes: 10 MHz system clock; all times in ms counted in 1 ms ticks, readback settle in clock cycles
// Notes:   Included by the package and the evaluator
`ifndef CDG_PARAMS_SVH
`define CDG_PARAMS_SVH

// Clock and tick base
`define CDG_CLK_NS        100          // System clock period in ns
`define CDG_TICK_NS       1000000      // Tick period in ns (1 ms)

// Widths
`define CDG_CODE_W        16           // Actuator code width
`define CDG_SEL_W         4            // Selector switch count
`define CDG_DATA_W        16           // Register data width
`define CDG_ADDR_W        8            // Register address width

// Times in ms (one tick each)
`define CDG_SELFTEST_MS   14'h2710     // Self-test, 10000 ms
`define CDG_MIN_DWELL_MS  14'h01f4     // Least actuator dwell, 500 ms
`define CDG_ST_HALF_MS    14'h0021     // Self-test blink half period, 33 ms (15 Hz)
`define CDG_TEACH_HALF_MS 14'h01f4     // Teach blink half period, 500 ms (1 Hz)
`define CDG_BURST_HALF_MS 14'h00c8     // Burst flash half period, 200 ms
`define CDG_PAUSE_MS      14'h03e8     // Pause between bursts, 1000 ms
`define CDG_TEACH_DWELL_MS 14'h03e8    // Actuator hold time to learn, 1000 ms

// Counts
`define CDG_MAX_TEACH     4'h8         // Teach-in operations allowed
`define CDG_CFG_FLASHES   4'h3         // Flashes per configuration fault burst
`define CDG_FB_FLASHES    4'h4         // Flashes per feedback fault burst
`define CDG_RB_SETTLE     3'h4         // Cycles before readback is compared

// Register offsets
`define CDG_REG_CTRL      8'h00        // Control, bit 0 requests teach-in
`define CDG_REG_STATUS    8'h04        // Live state
`define CDG_REG_IRQ_STAT  8'h08        // Sticky event bits, read only
`define CDG_REG_IRQ_CLR   8'h0c        // Write one to clear, write only
`define CDG_REG_IRQ_EN    8'h10        // Event enables
`define CDG_REG_CODE      8'h14        // Learned code, read only

// Field positions
`define CDG_CTRL_TEACH    0            // Teach-in request bit
`define CDG_SEL_MANUAL    0            // Selector bit for manual start
`define CDG_EV_FAULT      0            // Internal fault entered
`define CDG_EV_CFG        1            // Configuration fault entered
`define CDG_EV_FB         2            // Feedback loop fault entered
`define CDG_EV_TEACH      3            // Teach-in stored
`define CDG_EV_DOOR       4            // Door output changed
`define CDG_EV_N          5            // Number of events

`endif

// ---- cdg_pkg.sv ----
// Purpose: Types of the coded door guard evaluator
// Assumes: cdg_params.svh supplies widths
// Notes:   States are Gray along self-test, run, teach
`include "cdg_params.svh"

package cdg_pkg;

	// Operating states
	typedef enum logic [2:0] {
		ST_SELFTEST = 3'h0,  // Power-up self-test
		ST_RUN      = 3'h1,  // Normal operation
		ST_TEACH    = 3'h3,  // Learning an actuator
		ST_FAULT    = 3'h2,  // Internal fault, safe state
		ST_CFGF     = 3'h6,  // Configuration fault
		ST_FBF      = 3'h7   // Feedback loop fault
	} cdg_state_e;

	// Indicator set
	typedef struct packed {
		logic status;  // First indicator
		logic door;    // Door-closed indicator
		logic yellow;  // Combined indicator, actuator seen
		logic red;     // Combined indicator, fault
	} cdg_leds_s;

	// What teach-in learned
	typedef struct packed {
		logic [`CDG_CODE_W-1:0] code;      // Actuator code
		logic [`CDG_SEL_W-1:0]  sel;       // Selector setting
		logic                   fbTaught;  // Feedback loop present
		logic                   autoStart; // Automatic start mode
	} cdg_teach_s;

endpackage

// ---- cdg_evaluator.sv ----
// Purpose: Evaluation logic of a coded non-contact door safety switch
// Assumes: Pins are asynchronous and pass two flip-flops first
// Notes:   Learned data lives in flip-flops and is lost on reset
`timescale 1ns/1ns
`include "cdg_params.svh"

module cdg_evaluator #(
	parameter int TICK_CYC = `CDG_TICK_NS / `CDG_CLK_NS  // Cycles per 1 ms tick
) (
	input  wire logic                   sys_clk,      // System clock, 10 MHz
	input  wire logic                   rst_n,        // Asynchronous reset, active low
	input  wire logic [`CDG_ADDR_W-1:0] regAddr,      // Register byte address
	input  wire logic [`CDG_DATA_W-1:0] regWdata,     // Register write data
	input  wire logic                   regWr,        // Write strobe
	input  wire logic                   regRd,        // Read strobe
	output logic      [`CDG_DATA_W-1:0] regRdata,     // Read data, cycle after strobe
	output logic                        irq,          // Level interrupt
	input  wire logic                   actPresent,   // Actuator in operating distance
	input  wire logic [`CDG_CODE_W-1:0] actCode,      // Bit pattern read from actuator
	input  wire logic                   funcTest,     // function_test_input
	input  wire logic                   startBtn,     // Start button input
	input  wire logic [1:0]             fbLoop,       // feedback_loop_inputs
	input  wire logic                   teachJumper,  // teach_jumper_contacts closed
	input  wire logic [`CDG_SEL_W-1:0]  cfgSel,       // config_selector_switches
	input  wire logic [`CDG_SEL_W-1:0]  setupSense,   // Connected setup sensed
	input  wire logic                   readbackA,    // Monitor of safety_output_a
	input  wire logic                   readbackB,    // Monitor of safety_output_b
	input  wire logic                   compFail,     // Internal component failure
	output logic                        safetyOutA,   // safety_output_a
	output logic                        safetyOutB,   // safety_output_b
	output logic                        doorOut,      // Door monitoring output
	output cdg_pkg::cdg_leds_s          leds          // Indicators
);

	localparam int IN_W = `CDG_CODE_W + 2 * `CDG_SEL_W + 9;  // Synchronised pin count

	// Synchroniser stages and their decoded outputs
	logic [IN_W-1:0]              syncA;    // First stage
	logic [IN_W-1:0]              syncB;    // Second stage
	logic                         actS;     // Actuator present
	logic [`CDG_CODE_W-1:0]       codeS;    // Actuator code
	logic                         testS;    // Function test
	logic                         startS;   // Start button
	logic [1:0]                   fbS;      // Feedback loop
	logic                         jumpS;    // Teach jumper
	logic [`CDG_SEL_W-1:0]        selS;     // Selector switches
	logic [`CDG_SEL_W-1:0]        senseS;   // Sensed setup
	logic                         rbAS;     // Readback A
	logic                         rbBS;     // Readback B
	logic                         failS;    // Component failure

	// Timebase and state
	logic [23:0]                  preCnt;    // Prescaler
	logic                         tick;      // 1 ms pulse
	cdg_pkg::cdg_state_e          state;     // Operating state
	cdg_pkg::cdg_state_e          prevState; // State one cycle ago
	logic [13:0]                  stTicks;   // Ticks in current state
	logic [1:0]                   bootCnt;   // Cycles until straps settled
	logic                         booted;    // Strap capture done
	logic                         jumperBoot;// Jumper fitted at power-up
	logic                         jumpPrev;  // Jumper one cycle ago
	logic                         jumpRise;  // Jumper fitted while powered
	logic [13:0]                  dwell;     // Ticks actuator present
	logic                         actPrev;   // Actuator one cycle ago
	logic                         shortVisit;// Actuator left too soon
	cdg_pkg::cdg_teach_s          rec;       // Learned record
	logic [3:0]                   teachCnt;  // Teach-ins done
	logic [`CDG_SEL_W-1:0]        teachSel;  // Selector at teach entry
	logic [1:0]                   teachFb;   // Feedback loop at teach entry
	logic                         armed;     // Start pressed, manual mode
	logic [2:0]                   rbCnt;     // Cycles since output command settled
	logic                         rbBad;     // Readback disagrees
	logic                         match;     // Valid actuator
	logic                         cfgBad;    // Configuration check failed
	logic                         fbBad;     // Feedback loop check failed
	logic                         intFault;  // Any internal fault
	logic                         outOn;     // Safety outputs command
	logic                         teachReq;  // Software teach request

	// Indicator pattern
	logic [2:0]                   disp;      // Displayed pattern code
	logic [2:0]                   dispPrev;  // Pattern one cycle ago
	logic [13:0]                  segCnt;    // Ticks in current segment
	logic [3:0]                   pulseIdx;  // Burst segment index
	logic                         flashOn;   // Flash phase
	logic [13:0]                  segLen;    // Current segment length
	logic [3:0]                   burstN;    // Flashes per burst
	logic                         isBurst;   // Burst pattern active

	// Events and registers
	logic [`CDG_EV_N-1:0]         ev;        // Event pulses
	logic [`CDG_EV_N-1:0]         irqStat;   // Sticky events
	logic [`CDG_EV_N-1:0]         irqEn;     // Event enables
	logic                         doorPrev;  // Door output one cycle ago

	// True in states that light the fault indicator
	function automatic logic faultState(input cdg_pkg::cdg_state_e s);
		faultState = (s == cdg_pkg::ST_FAULT) || (s == cdg_pkg::ST_CFGF) ||
			(s == cdg_pkg::ST_FBF);
	endfunction

	// Two flip-flops on every pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= {actPresent, actCode, funcTest, startBtn, fbLoop, teachJumper,
				cfgSel, setupSense, readbackA, readbackB, compFail};
			syncB <= syncA;
		end
	end
	assign {actS, codeS, testS, startS, fbS, jumpS, selS, senseS, rbAS, rbBS, failS} = syncB;

	// Prescaler for all ms timing
	assign tick = (preCnt == 24'(TICK_CYC - 1));
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			preCnt <= '0;
		end else begin
			preCnt <= tick ? '0 : preCnt + 24'h1;
		end
	end

	// Time spent in the current state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevState <= cdg_pkg::ST_SELFTEST;
			stTicks   <= '0;
		end else begin
			prevState <= state;
			if (state != prevState) begin
				stTicks <= '0;
			end else if (tick && stTicks != 14'h3fff) begin
				stTicks <= stTicks + 14'h1;
			end
		end
	end

	// Catch the jumper once pins have settled, then watch for late insertion
	assign jumpRise = booted && jumpS && !jumpPrev;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bootCnt    <= '0;
			booted     <= 1'b0;
			jumperBoot <= 1'b0;
			jumpPrev   <= 1'b0;
		end else begin
			jumpPrev <= jumpS;
			if (!booted) begin
				bootCnt <= bootCnt + 2'h1;
				if (bootCnt == 2'h3) begin
					booted     <= 1'b1;
					jumperBoot <= jumpS;
				end
			end
		end
	end

	// Actuator dwell; a visit shorter than the least dwell is a fault
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dwell      <= '0;
			actPrev    <= 1'b0;
			shortVisit <= 1'b0;
		end else begin
			actPrev    <= actS;
			shortVisit <= actPrev && !actS && (dwell < `CDG_MIN_DWELL_MS);
			if (!actS) begin
				dwell <= '0;
			end else if (tick && dwell != 14'h3fff) begin
				dwell <= dwell + 14'h1;
			end
		end
	end

	// Checks feeding the state machine
	assign match  = actS && (teachCnt != 4'h0) && (codeS == rec.code);
	assign cfgBad = (selS == '0) ||
		(selS != rec.sel) ||
		((|fbS) && !rec.fbTaught) ||
		(rec.autoStart && startS);
	assign fbBad    = rec.fbTaught && (fbS[0] ^ fbS[1]);
	assign intFault = failS || rbBad || shortVisit;
	assign teachReq = regWr && (regAddr == `CDG_REG_CTRL) && regWdata[`CDG_CTRL_TEACH];

	// Operating state machine and teach-in store
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= cdg_pkg::ST_SELFTEST;
			rec      <= '0;
			teachCnt <= '0;
			teachSel <= '0;
			teachFb  <= '0;
		end else begin
			case (state)
				cdg_pkg::ST_SELFTEST: begin
					if (intFault) begin
						state <= cdg_pkg::ST_FAULT;
					end else if (stTicks == `CDG_SELFTEST_MS) begin
						state    <= jumperBoot ? cdg_pkg::ST_TEACH : cdg_pkg::ST_RUN;
						teachSel <= selS;
						teachFb  <= fbS;
					end
				end
				cdg_pkg::ST_RUN: begin
					if (intFault) begin
						state <= cdg_pkg::ST_FAULT;
					end else if (jumpRise || (teachCnt != 4'h0 && cfgBad)) begin
						state <= cdg_pkg::ST_CFGF;
					end else if (fbBad) begin
						state <= cdg_pkg::ST_FBF;
					end else if (teachReq) begin
						state    <= cdg_pkg::ST_TEACH;
						teachSel <= selS;
						teachFb  <= fbS;
					end
				end
				cdg_pkg::ST_TEACH: begin
					if (intFault) begin
						state <= cdg_pkg::ST_FAULT;
					end else if (teachCnt == `CDG_MAX_TEACH) begin
						state <= cdg_pkg::ST_RUN;
					end else if (jumpRise || selS != teachSel || fbS != teachFb ||
						selS == '0 || selS != senseS) begin
						state <= cdg_pkg::ST_CFGF;
					end else if (actS && dwell >= `CDG_TEACH_DWELL_MS) begin
						rec.code      <= codeS;
						rec.sel       <= selS;
						rec.fbTaught  <= |fbS;
						rec.autoStart <= !selS[`CDG_SEL_MANUAL];
						teachCnt      <= teachCnt + 4'h1;
						state         <= cdg_pkg::ST_RUN;
					end
				end
				cdg_pkg::ST_CFGF: begin
					if (intFault) begin
						state <= cdg_pkg::ST_FAULT;
					end else if (teachReq) begin
						state    <= cdg_pkg::ST_TEACH;
						teachSel <= selS;
						teachFb  <= fbS;
					end
				end
				cdg_pkg::ST_FBF: begin
					if (intFault) begin
						state <= cdg_pkg::ST_FAULT;
					end else if (!fbBad) begin
						state <= cdg_pkg::ST_RUN;
					end
				end
				default: begin
					state <= cdg_pkg::ST_FAULT;  // Held until reset
				end
			endcase
		end
	end

	// Manual start arming, cleared when the actuator is lost
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (!match || state != cdg_pkg::ST_RUN) begin
			armed <= 1'b0;
		end else if (startS) begin
			armed <= 1'b1;
		end
	end

	// Output command: match, start, released contactors, no test
	assign outOn = (state == cdg_pkg::ST_RUN) && match && !testS && !intFault &&
		(rec.autoStart || armed) &&
		(!rec.fbTaught || fbS == 2'h3 || safetyOutA);

	// Safety and door outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			safetyOutA <= 1'b0;
			safetyOutB <= 1'b0;
			doorOut    <= 1'b0;
		end else begin
			safetyOutA <= outOn;
			safetyOutB <= outOn;
			doorOut    <= (state == cdg_pkg::ST_RUN) && match;
		end
	end

	// Two readback channels compared once the command is steady
	assign rbBad = (rbCnt == `CDG_RB_SETTLE) && ((rbAS != safetyOutA) || (rbBS != safetyOutB));
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rbCnt <= '0;
		end else if (outOn != safetyOutA) begin
			rbCnt <= '0;
		end else if (rbCnt != `CDG_RB_SETTLE) begin
			rbCnt <= rbCnt + 3'h1;
		end
	end

	// Displayed pattern: 0 off,1 self-test,2 teach,3 on,4 cfg,5 fb,6 test
	always_comb begin
		disp = 3'h3;
		case (state)
			cdg_pkg::ST_SELFTEST: disp = 3'h1;
			cdg_pkg::ST_TEACH:    disp = 3'h2;
			cdg_pkg::ST_CFGF:     disp = 3'h4;
			cdg_pkg::ST_FBF:      disp = 3'h5;
			cdg_pkg::ST_FAULT:    disp = 3'h0;
			cdg_pkg::ST_RUN:      disp = testS ? 3'h6 : 3'h3;
			default:              disp = 3'h0;
		endcase
	end

	// Segment length and burst size of the pattern
	assign isBurst = (disp == 3'h4) || (disp == 3'h5);
	assign burstN  = (disp == 3'h4) ? `CDG_CFG_FLASHES : `CDG_FB_FLASHES;
	always_comb begin
		segLen = `CDG_BURST_HALF_MS;
		if (disp == 3'h1) begin
			segLen = `CDG_ST_HALF_MS;
		end else if (disp == 3'h2) begin
			segLen = `CDG_TEACH_HALF_MS;
		end else if (isBurst && pulseIdx == {burstN[2:0], 1'b0}) begin
			segLen = `CDG_PAUSE_MS;
		end
	end

	// Flash sequencer, restarted from the first flash on a pattern change
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dispPrev <= '0;
			segCnt   <= '0;
			pulseIdx <= '0;
			flashOn  <= 1'b1;
		end else begin
			dispPrev <= disp;
			if (disp != dispPrev) begin
				segCnt   <= '0;
				pulseIdx <= '0;
				flashOn  <= 1'b1;
			end else if (tick) begin
				if (segCnt + 14'h1 >= segLen) begin
					segCnt <= '0;
					if (!isBurst) begin
						flashOn <= !flashOn;
					end else if (pulseIdx == {burstN[2:0], 1'b0}) begin
						pulseIdx <= '0;
						flashOn  <= 1'b1;
					end else begin
						pulseIdx <= pulseIdx + 4'h1;
						flashOn  <= pulseIdx[0] && (pulseIdx + 4'h1 < {burstN[2:0], 1'b0});
					end
				end else begin
					segCnt <= segCnt + 14'h1;
				end
			end
		end
	end

	// Indicators
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			leds <= '0;
		end else begin
			leds.status <= (disp == 3'h3 || disp == 3'h6) ? 1'b1 :
				(disp == 3'h0) ? 1'b0 : flashOn;
			leds.door   <= (disp == 3'h3) && outOn;
			leds.red    <= faultState(state) || (disp == 3'h6);
			leds.yellow <= match && (disp == 3'h3);
		end
	end

	// Events for the interrupt status
	always_comb begin
		ev = '0;
		ev[`CDG_EV_FAULT] = (state == cdg_pkg::ST_FAULT) && (prevState != cdg_pkg::ST_FAULT);
		ev[`CDG_EV_CFG]   = (state == cdg_pkg::ST_CFGF) && (prevState != cdg_pkg::ST_CFGF);
		ev[`CDG_EV_FB]    = (state == cdg_pkg::ST_FBF) && (prevState != cdg_pkg::ST_FBF);
		ev[`CDG_EV_TEACH] = (prevState == cdg_pkg::ST_TEACH) && (state == cdg_pkg::ST_RUN);
		ev[`CDG_EV_DOOR]  = doorOut != doorPrev;
	end

	// Sticky status, set wins over clear; enables; interrupt line
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat  <= '0;
			irqEn    <= '0;
			doorPrev <= 1'b0;
			irq      <= 1'b0;
		end else begin
			doorPrev <= doorOut;
			if (regWr && regAddr == `CDG_REG_IRQ_CLR) begin
				irqStat <= (irqStat & ~regWdata[`CDG_EV_N-1:0]) | ev;
			end else begin
				irqStat <= irqStat | ev;
			end
			if (regWr && regAddr == `CDG_REG_IRQ_EN) begin
				irqEn <= regWdata[`CDG_EV_N-1:0];
			end
			irq <= |(irqStat & irqEn);
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= '0;
		end else if (regRd) begin
			case (regAddr)
				`CDG_REG_STATUS:   regRdata <= {5'h00, teachCnt, state, safetyOutB,
					safetyOutA, doorOut, match};
				`CDG_REG_IRQ_STAT: regRdata <= {{(`CDG_DATA_W - `CDG_EV_N){1'b0}}, irqStat};
				`CDG_REG_IRQ_EN:   regRdata <= {{(`CDG_DATA_W - `CDG_EV_N){1'b0}}, irqEn};
				`CDG_REG_CODE:     regRdata <= rec.code;
				default:           regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end

endmodule

// ---- cdg_evaluator_sva.sv ----
// Purpose: Port assertions of the evaluator
// Assumes: Pins pass two sync flops before the logic
// Notes:   Bound to every evaluator instance
`timescale 1ns/1ns
module cdg_evaluator_sva (
	input wire logic               sys_clk,    // Clock
	input wire logic               rst_n,      // Reset, active low
	input wire logic               actPresent, // Actuator seen
	input wire logic               funcTest,   // Test input
	input wire logic               compFail,   // Failure input
	input wire logic               readbackA,  // Monitor A
	input wire logic               readbackB,  // Monitor B
	input wire logic               safetyOutA, // Output A
	input wire logic               safetyOutB, // Output B
	input wire logic               doorOut,    // Door output
	input wire cdg_pkg::cdg_leds_s leds        // Indicators
);
	logic [3:0] mmCnt; // Cycles a monitor disagrees
	// Count disagreement, saturating; a stuck monitor must end in the safe state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			mmCnt <= 4'h0;
		else if (readbackA != safetyOutA || readbackB != safetyOutB)
			mmCnt <= (mmCnt == 4'hf) ? mmCnt : mmCnt + 4'h1;
		else
			mmCnt <= 4'h0;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence sLost;
		!actPresent [*4];
	endsequence
	a_boot_safe: assert property ($rose(rst_n) |-> (!safetyOutA && !safetyOutB) [*8])
		else $error("output on during self-test");
	a_test_off: assert property (funcTest [*5] |-> !safetyOutA && !safetyOutB)
		else $error("output on in function test");
	a_fault_off: assert property (compFail |-> ##[1:8] (!safetyOutA && leds.red))
		else $error("failure not shown");
	a_red_off: assert property (leds.red [*3] |-> !safetyOutA && !safetyOutB)
		else $error("output on with red");
	a_lost_drop: assert property (sLost |=> !safetyOutA && !safetyOutB && !doorOut)
		else $error("output on without actuator");
	a_lost_dark: assert property (sLost |=> !leds.yellow)
		else $error("yellow without actuator");
	a_door_led: assert property (leds.door |-> safetyOutA || $past(safetyOutA))
		else $error("door lamp without outputs");
	a_readback_chk: assert property (mmCnt < 4'hc)
		else $error("monitor mismatch ignored");
endmodule
bind cdg_evaluator cdg_evaluator_sva i_sva (.sys_clk(sys_clk), .rst_n(rst_n),
	.actPresent(actPresent), .funcTest(funcTest), .compFail(compFail), .readbackA(readbackA),
	.readbackB(readbackB), .safetyOutA(safetyOutA), .safetyOutB(safetyOutB),
	.doorOut(doorOut), .leds(leds));

// ---- cdg_partner.sv ----
// Purpose: Switchgear monitors that echo the safety outputs
// Assumes: Monitors lag the outputs by one clock
// Notes:   stickB holds monitor B low to provoke a readback fault
`timescale 1ns/1ns
module cdg_partner (
	input  wire logic sys_clk,    // Clock
	input  wire logic safetyOutA, // Output A on the wire
	input  wire logic safetyOutB, // Output B on the wire
	input  wire logic stickB,     // Hold monitor B low
	output logic      readbackA,  // Monitor A
	output logic      readbackB   // Monitor B
);
	// Two separate channels echo the outputs
	always_ff @(posedge sys_clk) begin
		readbackA <= safetyOutA;
		readbackB <= safetyOutB && !stickB;
	end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the evaluator
// Assumes: TICK_CYC of 2, so one tick is two clocks
// Notes:   Boots with jumper in, learns a random code, then faults
`timescale 1ns/1ns
module tb_top;
	localparam int TK = 2; // Clocks per tick
	logic sys_clk, rst_n, regWr, regRd, actPresent, funcTest, startBtn, compFail, stickB;
	logic readbackA, readbackB, safetyOutA, safetyOutB, doorOut, irq;
	logic [7:0] regAddr;                       // Bus address
	logic [3:0] cfgSel, setupSense;            // Selector and sensed setup
	logic [15:0] regWdata, regRdata, actCode, code, rd; // Bus data, codes
	logic [31:0] lfsr;                         // Random state
	cdg_pkg::cdg_leds_s leds;                  // Indicators
	int failCount, checksDone, cyc, hi;        // Counters
	cdg_evaluator #(.TICK_CYC(TK)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
		.actPresent(actPresent), .actCode(actCode), .funcTest(funcTest), .startBtn(startBtn),
		.fbLoop(2'h0), .teachJumper(1'b1), .cfgSel(cfgSel), .setupSense(setupSense),
		.readbackA(readbackA), .readbackB(readbackB), .compFail(compFail),
		.safetyOutA(safetyOutA), .safetyOutB(safetyOutB), .doorOut(doorOut), .leds(leds));
	cdg_partner i_far (.sys_clk(sys_clk), .safetyOutA(safetyOutA), .safetyOutB(safetyOutB),
		.stickB(stickB), .readbackA(readbackA), .readbackB(readbackB));
	// Clock of 100 ns
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Cut a hang short
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failCount++;
			stopTest();
		end
	end
	function automatic logic [31:0] nextRand(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rdReg(logic [7:0] a);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#10 rd = regRdata;
	endtask
	// Hold the learned code until stored, then expect run with count n
	task automatic teach(logic [3:0] n);
		@(posedge sys_clk);
		actCode <= code;
		actPresent <= 1'b1;
		step(1000 * TK + 50);
		rdReg(8'h04);
		chk(rd[10:4], {n, 3'h1});
	endtask
	task automatic stopTest;
		if (failCount == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{regWr, regRd, actPresent, funcTest, startBtn, compFail, stickB} = 7'h00;
		{regAddr, regWdata, actCode} = 40'h0;
		{cfgSel, setupSense} = 8'h22;
		rst_n = 1'b0;
		lfsr = nextRand(32'h08e6);
		code = lfsr[15:0];
		step(4);
		rst_n = 1'b1;
		wr(8'h10, 16'h001f);
		rdReg(8'h04);
		chk(rd[6:4], 16'h0);
		chk({leds.door, leds.red}, 16'h0);
		step(10000 * TK + 50);
		rdReg(8'h04);
		chk({rd[6:4], leds.door, leds.yellow, leds.red}, 16'h18);
		teach(4'h1);
		rdReg(8'h14);
		chk(rd, code);
		rdReg(8'h08);
		chk({rd[3], irq}, 16'h3);
		chk({safetyOutA, safetyOutB, doorOut, leds.yellow, leds.door}, 16'h1f);
		funcTest <= 1'b1;
		step(6);
		chk({safetyOutA, safetyOutB, leds}, 16'h9);
		funcTest <= 1'b0;
		step(6);
		wr(8'h0c, 16'h001f);
		rdReg(8'h3c);
		chk(rd, 16'h0);
		chk(irq, 16'h0);
		step(500 * TK);
		actPresent <= 1'b0;
		step(6);
		chk({safetyOutA, safetyOutB, doorOut, leds.yellow}, 16'h0);
		actCode <= code ^ {lfsr[31:17], 1'b1};
		actPresent <= 1'b1;
		step(600 * TK);
		chk({safetyOutA, safetyOutB, doorOut}, 16'h0);
		{actPresent, funcTest} <= 2'h1;
		step(6);
		chk(leds, 16'h9);
		{funcTest, startBtn} <= 2'h1;
		step(6);
		hi = 0;
		repeat (4000) begin
			@(negedge sys_clk);
			hi += leds.status;
		end
		chk(hi >= 1180 && hi <= 1200, 16'h1);
		rdReg(8'h04);
		chk({rd[6:4], leds.red}, 16'hd);
		startBtn <= 1'b0;
		wr(8'h00, 16'h0001);
		teach(4'h2);
		step(600 * TK);
		chk({safetyOutA, doorOut}, 16'h3);
		{cfgSel, setupSense} <= 8'h33;
		step(6);
		rdReg(8'h04);
		chk(rd[6:4], 16'h6);
		wr(8'h00, 16'h0001);
		teach(4'h3);
		chk({safetyOutA, doorOut, leds.door}, 16'h2);
		startBtn <= 1'b1;
		step(6);
		chk({safetyOutA, safetyOutB, leds.door}, 16'h7);
		startBtn <= 1'b0;
		repeat (6) wr(8'h00, 16'h0001);
		rdReg(8'h04);
		chk(rd[10:4], 16'h41);
		startBtn <= 1'b1;
		step(6);
		startBtn <= 1'b0;
		stickB <= 1'b1;
		step(20);
		rdReg(8'h04);
		chk({rd[6:3], leds.red}, 16'h9);
		compFail <= 1'b1;
		step(10);
		rst_n = 1'b0;
		step(2);
		chk({safetyOutA, safetyOutB, doorOut, leds}, 16'h0);
		stopTest();
	end
endmodule
